// ### rtl/hpb_regs.svh
// Constants of the host parallel port bridge
`ifndef HPB_REGS_SVH
`define HPB_REGS_SVH
`define HPB_CLK_NS       10
`define HPB_BUSY_MAX_NS  100000
`define HPB_INIT_MAX_NS  1000000
`define HPB_MODE_16_16   2'h0
`define HPB_MODE_8_8     2'h1
`define HPB_MODE_8_16    2'h2
`define HPB_MODE_SERIAL  2'h3
`define HPB_STAT_RDY_BIT 0
`define HPB_STAT_INT_BIT 1
`define HPB_WORD_RST     16'h0000
`endif

// ### rtl/hpb_pkg.sv
// Types of the host parallel port bridge
package hpb_pkg;
    typedef struct packed {
        logic        sel_n;
        logic        rd_n;
        logic        wr_n;
        logic        cmd;
        logic [15:0] data;
    } hpb_host_t;

    typedef struct packed {
        logic        rnw;
        logic        strobe_n;
        logic        periph_n;
        logic        a0;
        logic        a1;
        logic        a15;
    } hpb_core_t;

    typedef enum logic [2:0] {
        HPB_INIT  = 3'b001,
        HPB_READY = 3'b010,
        HPB_BUSY  = 3'b100
    } hpb_state_t;
endpackage : hpb_pkg

// ### rtl/hpb_port.sv
// Host parallel port bridge with core bus decode and core clock divider
// Overview of operation
// (RQ1) Command high: instruction write, status read
// (RQ2) Command low: data word transfer
// (RQ3) 8/8: busy after instruction byte, data word
// (RQ4) 8/16: busy after second byte of words
// (RQ5) 16/16: busy after each 16-bit word
// (RQ6) Ready returns once transfer processed
// (RQ7) Host waits for ready before transferring
// (RQ8) Busy period never exceeds 100 us
// (RQ9) Read strobe low presents data word
// (RQ10) Write strobe accepts host data word
// (RQ11) Strobes honoured only while selected
// (RQ12) Interrupt core on each host transfer; code does so only when ready drops, not on status reads or first bytes
// (RQ13) Core read/write line gives direction
// (RQ14) Core strobe low marks valid bus
// (RQ15) Core peripheral select low when addressed
// (RQ16) Own access needs address bits 0,1,15 high
// (RQ17) Core clock is half master clock
// (RQ18) Reset held at least 5 us
// (RQ19) Ready within 1 ms after reset
// (RQ20) Mode pins pick 16/16, 8/8, 8/16, serial
// (RQ21) 8-bit modes use low eight lines
// (RQ22) Ready low until initialisation completes
// (RQ23) Bytes pair high byte first
`include "hpb_regs.svh"

module hpb_port
    import hpb_pkg::*;
#(
    parameter int BUSY_MAX_CYC = `HPB_BUSY_MAX_NS / `HPB_CLK_NS,
    parameter int INIT_CYC     = `HPB_INIT_MAX_NS / `HPB_CLK_NS
) (
    input  wire logic      clock_i,
    input  wire logic      sys_rst_i,
    input  wire hpb_host_t host_i,
    input  wire logic      port_mode_select0_i,
    input  wire logic      port_mode_select1_i,
    input  wire logic      host_interrupt_flag_i,
    input  wire hpb_core_t core_i,
    input  wire logic [15:0] core_data_i,
    output logic [15:0]    host_data_bus_o,
    output logic           host_data_bus_oe_n_o,
    output logic           port_ready_flag_o,
    output logic           core_interrupt_out_o,
    output logic [15:0]    core_data_o,
    output logic           core_data_oe_n_o,
    output logic           core_word_is_cmd_o,
    output logic           core_clock_out_o
);
    localparam int CW = $clog2(INIT_CYC + 1);

    initial begin
        if (INIT_CYC < 1 || BUSY_MAX_CYC < 1 || BUSY_MAX_CYC > INIT_CYC)
            $error("hpb_port: bad cycle counts");
    end

    // Pin synchronisers; stage 1 feeds stage 2 only
    hpb_host_t   host_s1, host_s2, host_s3;
    hpb_core_t   core_s1, core_s2, core_s3;
    logic [15:0] cdat_s1, cdat_s2;
    logic [1:0]  mode_s1, mode_s2;
    logic        hint_s1, hint_s2;

    always_ff @(posedge clock_i) begin
        host_s1 <= host_i;
        host_s2 <= host_s1;
        host_s3 <= host_s2;
        core_s1 <= core_i;
        core_s2 <= core_s1;
        core_s3 <= core_s2;
        cdat_s1 <= core_data_i;
        cdat_s2 <= cdat_s1;
        mode_s1 <= {port_mode_select1_i, port_mode_select0_i};
        mode_s2 <= mode_s1;
        hint_s1 <= host_interrupt_flag_i;
        hint_s2 <= hint_s1;
    end

    logic mode16, mode88, mode816, parallel;
    logic wr_done, rd_done, core_sel, core_done;

    always_comb begin
        mode16   = (mode_s2 == `HPB_MODE_16_16);                               // [RQ20]
        mode88   = (mode_s2 == `HPB_MODE_8_8);                                 // [RQ20]
        mode816  = (mode_s2 == `HPB_MODE_8_16);                                // [RQ20]
        parallel = (mode_s2 != `HPB_MODE_SERIAL);                              // [RQ20]
        // Strobe end while selected
        wr_done  = !host_s3.wr_n && host_s2.wr_n && !host_s3.sel_n && parallel; // [RQ10] [RQ11]
        rd_done  = !host_s3.rd_n && host_s2.rd_n && !host_s3.sel_n && parallel; // [RQ9] [RQ11]
        core_sel = !core_s2.periph_n && core_s2.a0 && core_s2.a1 && core_s2.a15; // [RQ15] [RQ16]
        core_done = !core_s3.strobe_n && core_s2.strobe_n && !core_s3.periph_n
                    && core_s3.a0 && core_s3.a1 && core_s3.a15;                 // [RQ14] [RQ16]
    end

    hpb_state_t  state, next_state;
    logic [CW-1:0] cnt, next_cnt;
    logic        phase, next_phase;
    logic [7:0]  hi_byte, next_hi_byte;
    logic [15:0] in_word, next_in_word;
    logic        in_cmd, next_in_cmd;
    logic [15:0] rd_word, next_rd_word;
    logic        cint, next_cint;
    logic [15:0] next_hdata;
    logic        next_hoe_n;
    logic [15:0] next_cdata;
    logic        next_coe_n;
    logic        cclk, next_cclk;

    always_comb begin
        next_state   = state;
        next_cnt     = cnt;
        next_phase   = phase;
        next_hi_byte = hi_byte;
        next_in_word = in_word;
        next_in_cmd  = in_cmd;
        next_rd_word = rd_word;
        next_cint    = cint;
        next_cclk    = !cclk;                                                  // [RQ17]
        // Core writes the word that the host reads next
        if (core_sel && !core_s2.rnw && !core_s2.strobe_n)                     // [RQ13]
            next_rd_word = cdat_s2;
        case (state)
            HPB_INIT: begin
                next_cnt = cnt + CW'(1);
                if (cnt == CW'(INIT_CYC - 1)) begin                            // [RQ19] [RQ22]
                    next_state = HPB_READY;
                    next_cnt   = '0;
                end
            end
            HPB_READY: begin
                // Transfers taken only while ready
                if (wr_done) begin
                    if (host_s3.cmd && mode88) begin                           // [RQ1] [RQ3]
                        next_in_word = {8'h00, host_s3.data[7:0]};
                        next_in_cmd  = 1'b1;
                        next_state   = HPB_BUSY;
                    end else if (mode16) begin                                 // [RQ5] [RQ2]
                        next_in_word = host_s3.data;
                        next_in_cmd  = host_s3.cmd;
                        next_state   = HPB_BUSY;
                    end else if (!phase) begin                                 // [RQ23] [RQ21]
                        next_hi_byte = host_s3.data[7:0];
                        next_phase   = 1'b1;
                    end else begin                                             // [RQ4] [RQ3]
                        next_in_word = {hi_byte, host_s3.data[7:0]};
                        next_in_cmd  = host_s3.cmd;
                        next_phase   = 1'b0;
                        next_state   = HPB_BUSY;
                    end
                end else if (rd_done && !host_s3.cmd) begin                    // [RQ2]
                    if (mode16 || phase) begin                                 // [RQ5] [RQ3] [RQ4]
                        next_phase = 1'b0;
                        next_state = HPB_BUSY;
                    end else begin
                        next_phase = 1'b1;                                     // [RQ23]
                    end
                end
                if (next_state == HPB_BUSY) begin
                    next_cint = 1'b1;                                          // [RQ12]
                    next_cnt  = '0;
                end
            end
            HPB_BUSY: begin
                next_cnt = cnt + CW'(1);
                if (core_done || cnt == CW'(BUSY_MAX_CYC - 1)) begin           // [RQ6] [RQ8]
                    next_state = HPB_READY;
                    next_cint  = 1'b0;
                    next_cnt   = '0;
                end
            end
            default: begin
                next_state = HPB_INIT;
                next_cnt   = '0;
            end
        endcase
        // Host read data: status, full word or one byte
        if (host_s2.cmd) begin                                                 // [RQ1]
            next_hdata = `HPB_WORD_RST;
            next_hdata[`HPB_STAT_RDY_BIT] = (state == HPB_READY);
            next_hdata[`HPB_STAT_INT_BIT] = hint_s2;
        end else if (mode16) begin                                             // [RQ9] [RQ21]
            next_hdata = rd_word;
        end else begin                                                         // [RQ21] [RQ23]
            next_hdata = {8'h00, phase ? rd_word[7:0] : rd_word[15:8]};
        end
        next_hoe_n = !(!host_s2.sel_n && !host_s2.rd_n && parallel
                       && state != HPB_INIT);                                  // [RQ9] [RQ11]
        next_cdata = in_word;
        next_coe_n = !(core_sel && core_s2.rnw && !core_s2.strobe_n);          // [RQ13] [RQ14]
    end

    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            state                <= HPB_INIT;                                  // [RQ22]
            cnt                  <= '0;
            phase                <= 1'b0;
            hi_byte              <= 8'h00;
            in_word              <= `HPB_WORD_RST;
            in_cmd               <= 1'b0;
            rd_word              <= `HPB_WORD_RST;
            cint                 <= 1'b0;
            cclk                 <= 1'b0;
            host_data_bus_o      <= `HPB_WORD_RST;
            host_data_bus_oe_n_o <= 1'b1;
            core_data_o          <= `HPB_WORD_RST;
            core_data_oe_n_o     <= 1'b1;
        end else begin
            state                <= next_state;
            cnt                  <= next_cnt;
            phase                <= next_phase;
            hi_byte              <= next_hi_byte;
            in_word              <= next_in_word;
            in_cmd               <= next_in_cmd;
            rd_word              <= next_rd_word;
            cint                 <= next_cint;
            cclk                 <= next_cclk;
            host_data_bus_o      <= next_hdata;
            host_data_bus_oe_n_o <= next_hoe_n;
            core_data_o          <= next_cdata;
            core_data_oe_n_o     <= next_coe_n;
        end
    end

    assign port_ready_flag_o    = (state == HPB_READY);                        // [RQ6] [RQ7]
    assign core_interrupt_out_o = cint;                                        // [RQ12]
    assign core_word_is_cmd_o   = in_cmd;
    assign core_clock_out_o     = cclk;                                        // [RQ17]

    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (sys_rst_i);

    init_ready_low_a: assert property (state == HPB_INIT |-> !port_ready_flag_o) // [RQ22]
        else $error("ready high during init");
    busy_bound_a: assert property (state == HPB_BUSY |-> cnt < CW'(BUSY_MAX_CYC)) // [RQ8]
        else $error("busy period too long");
    word16_busy_a: assert property (state == HPB_READY && wr_done && mode16 // [RQ5]
                                    |=> !port_ready_flag_o)
        else $error("16/16 word did not drop ready");
    cmd88_busy_a: assert property (state == HPB_READY && wr_done && host_s3.cmd && mode88 // [RQ3]
                                   |=> !port_ready_flag_o ##0 in_cmd)
        else $error("8/8 instruction did not drop ready");
    first_byte_a: assert property (state == HPB_READY && wr_done && mode816 && !phase // [RQ4]
                                   |=> port_ready_flag_o ##0 phase)
        else $error("first byte dropped ready");
    core_irq_a: assert property (state == HPB_READY ##1 state == HPB_BUSY // [RQ12]
                                 |-> core_interrupt_out_o)
        else $error("no core interrupt on transfer");
    clock_half_a: assert property (!$past(sys_rst_i) // [RQ17]
                                   |-> core_clock_out_o != $past(core_clock_out_o))
        else $error("core clock not divided by two");
    host_drive_sel_a: assert property (!host_data_bus_oe_n_o // [RQ11]
                                       |-> !$past(host_s2.sel_n) && !$past(host_s2.rd_n))
        else $error("host bus driven unselected");
    status_read_a: assert property (!host_data_bus_oe_n_o && $past(host_s2.cmd) // [RQ1]
                                    |-> host_data_bus_o[`HPB_STAT_RDY_BIT] == $past(port_ready_flag_o))
        else $error("status bit wrong");
    core_decode_a: assert property (!core_data_oe_n_o // [RQ16]
                                    |-> $past(core_s2.a0 && core_s2.a1 && core_s2.a15 && core_s2.rnw))
        else $error("core bus driven undecoded");
    release_a: assert property (state == HPB_BUSY && core_done |=> port_ready_flag_o) // [RQ6]
        else $error("ready not restored");
    byte_lanes_a: assert property (!host_data_bus_oe_n_o && !$past(host_s2.cmd) && !$past(mode16) // [RQ21]
                                   |-> host_data_bus_o[15:8] == 8'h00)
        else $error("upper lanes in 8-bit mode");

    // Refused strobes and word paths
    status_keep_a: assert property (state == HPB_READY && rd_done && host_s3.cmd && !wr_done // [RQ1]
                                    |=> port_ready_flag_o)
        else $error("status read dropped ready");
    read_busy_a: assert property (state == HPB_READY && rd_done && !host_s3.cmd && !wr_done // [RQ2]
                                  && (mode16 || phase) |=> !port_ready_flag_o)
        else $error("data read did not drop ready");
    desel_ignore_a: assert property (state == HPB_READY && host_s3.sel_n |=> port_ready_flag_o) // [RQ11]
        else $error("deselected strobe taken");
    serial_ignore_a: assert property (state == HPB_READY && !parallel |=> port_ready_flag_o) // [RQ20]
        else $error("strobe taken in serial mode");
    foreign_ignore_a: assert property (state == HPB_BUSY && !core_s3.a15 && cnt != CW'(BUSY_MAX_CYC - 1) // [RQ16]
                                       |=> !port_ready_flag_o)
        else $error("foreign address released ready");
    irq_idle_a: assert property (port_ready_flag_o |-> !core_interrupt_out_o) // [RQ12]
        else $error("core interrupt while ready");
    word_take_a: assert property (state == HPB_READY && wr_done && mode16 // [RQ10]
                                  |=> in_word == $past(host_s3.data))
        else $error("host word not taken");
    pair_order_a: assert property (state == HPB_READY && wr_done && !mode16 && phase // [RQ23]
                                   && !(host_s3.cmd && mode88) |=> in_word[15:8] == $past(hi_byte))
        else $error("byte pair order wrong");
    core_write_a: assert property (core_sel && !core_s2.rnw && !core_s2.strobe_n // [RQ13]
                                   |=> rd_word == $past(cdat_s2))
        else $error("core word not latched");
    core_drive_a: assert property (!core_data_oe_n_o // [RQ14] [RQ15]
                                   |-> $past(!core_s2.strobe_n && !core_s2.periph_n))
        else $error("core bus driven without strobe");

    word_write_c: cover property (state == HPB_READY && wr_done ##1 state == HPB_BUSY ##[1:50] core_done);
    byte_pair_c: cover property (wr_done && mode816 && !phase ##[1:50] wr_done && phase);
    busy_timeout_c: cover property (state == HPB_BUSY && cnt == CW'(BUSY_MAX_CYC - 1));
    status_read_c: cover property (state == HPB_READY && rd_done && host_s3.cmd);
    serial_refuse_c: cover property (!parallel && !host_s3.wr_n ##1 host_s3.wr_n);
endmodule : hpb_port

// ### tb/hpb_host_model.sv
// Host processor model that drives the parallel port strobes
module hpb_host_model
    import hpb_pkg::*;
(
    input  wire logic        clock_i,
    input  wire logic        ready_i,
    input  wire logic [15:0] data_i,
    output hpb_host_t        host_o
);
    timeunit 1ns;
    timeprecision 1ps;

    logic timeout = 1'b0;

    initial host_o = '{1'b1, 1'b1, 1'b1, 1'b0, 16'hFFFF};

    // One strobe cycle, held 5 clocks low and 3 high
    task automatic xfer(input logic wr, input logic cmd, input logic sel_n,
                        input logic [15:0] wdata, output logic [15:0] rdata);
        int n;
        n = 0;
        @(negedge clock_i);
        while (ready_i !== 1'b1 && n < 200) begin
            @(negedge clock_i);
            n++;
        end
        timeout = (n >= 200);
        @(posedge clock_i);
        host_o.sel_n <= sel_n;
        host_o.cmd   <= cmd;
        host_o.data  <= wr ? wdata : ~host_o.data;
        host_o.wr_n  <= ~wr;
        host_o.rd_n  <= wr;
        repeat (4) @(posedge clock_i);
        @(negedge clock_i);
        rdata = data_i;
        @(posedge clock_i);
        host_o.wr_n  <= 1'b1;
        host_o.rd_n  <= 1'b1;
        host_o.sel_n <= 1'b1;
        host_o.data  <= ~host_o.data;
        repeat (3) @(posedge clock_i);
    endtask : xfer
endmodule : hpb_host_model

// ### tb/tb.sv
// Self-checking bench of the host parallel port bridge
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import hpb_pkg::*;

    localparam int INIT_CYC = 20;
    localparam int BUSY_CYC = 16;
    localparam hpb_core_t CORE_IDLE = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1};

    logic        clock_i   = 1'b0;
    logic        sys_rst_i = 1'b1;
    hpb_host_t   host;
    logic        mode0     = 1'b0;
    logic        mode1     = 1'b0;
    logic        hint      = 1'b0;
    hpb_core_t   core      = CORE_IDLE;
    logic [15:0] cdata     = 16'h0000;
    logic [15:0] hdata;
    logic [15:0] cword;
    logic [15:0] rd;
    logic        hoe_n;
    logic        coe_n;
    logic        ready;
    logic        cint;
    logic        is_cmd;
    logic        cclk;
    int          error_cnt = 0;
    int          checks    = 0;
    int          n;

    always #5 clock_i = ~clock_i;

    hpb_port #(.BUSY_MAX_CYC(BUSY_CYC), .INIT_CYC(INIT_CYC)) i_hpb_port (
        .clock_i(clock_i), .sys_rst_i(sys_rst_i), .host_i(host),
        .port_mode_select0_i(mode0), .port_mode_select1_i(mode1),
        .host_interrupt_flag_i(hint), .core_i(core), .core_data_i(cdata),
        .host_data_bus_o(hdata), .host_data_bus_oe_n_o(hoe_n), .port_ready_flag_o(ready),
        .core_interrupt_out_o(cint), .core_data_o(cword), .core_data_oe_n_o(coe_n),
        .core_word_is_cmd_o(is_cmd), .core_clock_out_o(cclk));

    hpb_host_model i_hpb_host_model (
        .clock_i(clock_i), .ready_i(ready), .data_i(hdata), .host_o(host));

    task automatic final_report;
        $display("Checks %0d, mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : final_report

    task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    task automatic hxfer(input logic wr, input logic cmd, input logic sel_n, input logic [15:0] d);
        i_hpb_host_model.xfer(wr, cmd, sel_n, d, rd);
        if (i_hpb_host_model.timeout) begin
            error_cnt++;
            $display("MISMATCH host wait expected 1 seen 0");
            final_report();
        end
    endtask : hxfer

    task automatic wait_ready(input logic exp, input int bound);
        n = 0;
        @(negedge clock_i);
        while (ready !== exp && n < bound) begin
            @(negedge clock_i);
            n++;
        end
        if (n >= bound) begin
            error_cnt++;
            $display("MISMATCH ready wait expected %b seen %b", exp, ready);
            final_report();
        end
    endtask : wait_ready

    task automatic stays_ready(input string name);
        repeat (5) @(negedge clock_i);
        check(name, 16'h0001, {15'h0000, ready});
    endtask : stays_ready

    // Core bus access, strobe low 4 clocks, then bus released
    task automatic core_acc(input logic rnw, input logic a15, input logic [15:0] d);
        @(posedge clock_i);
        core  <= '{rnw, 1'b0, 1'b0, 1'b1, 1'b1, a15};
        cdata <= d;
        repeat (3) @(posedge clock_i);
        @(negedge clock_i);
        check("core drive", {15'h0000, ~(rnw & a15)}, {15'h0000, coe_n});
        @(posedge clock_i);
        core.strobe_n <= 1'b1;
        repeat (4) @(posedge clock_i);
        core  <= CORE_IDLE;
        cdata <= ~d;
        repeat (3) @(posedge clock_i);
        @(negedge clock_i);
    endtask : core_acc

    task automatic set_mode(input logic m1, input logic m0);
        @(posedge clock_i);
        mode1 <= m1;
        mode0 <= m0;
        repeat (5) @(posedge clock_i);
    endtask : set_mode

    task automatic sc_reset;
        wait_ready(1'b1, INIT_CYC + 8);
        check("init busy", 16'h0001, {15'h0000, n >= INIT_CYC - 3});
        @(negedge clock_i);
        rd[0] = cclk;
        @(negedge clock_i);
        check("core clock", {15'h0000, ~rd[0]}, {15'h0000, cclk});
    endtask : sc_reset

    task automatic sc_word16;
        hxfer(1'b1, 1'b0, 1'b0, 16'hA5C3);
        wait_ready(1'b0, 6);
        @(negedge clock_i);
        check("data word", 16'hA5C3, cword);
        check("cmd flag", 16'h0000, {15'h0000, is_cmd});
        check("core irq", 16'h0001, {15'h0000, cint});
        core_acc(1'b1, 1'b1, 16'h0000);
        wait_ready(1'b1, 8);
        check("irq clear", 16'h0000, {15'h0000, cint});
        hxfer(1'b1, 1'b1, 1'b0, 16'h0F0F);
        wait_ready(1'b0, 6);
        check("instr flag", 16'h0001, {15'h0000, is_cmd});
        core_acc(1'b1, 1'b0, 16'h0000);
        check("foreign addr", 16'h0000, {15'h0000, ready});
        core_acc(1'b0, 1'b1, 16'h1234);
        wait_ready(1'b1, 8);
    endtask : sc_word16

    task automatic sc_read16;
        @(posedge clock_i);
        hint <= 1'b1;
        hxfer(1'b0, 1'b1, 1'b0, 16'h0000);
        check("status", 16'h0003, rd);
        stays_ready("status ready");
        hxfer(1'b0, 1'b0, 1'b0, 16'h0000);
        check("read word", 16'h1234, rd);
        wait_ready(1'b0, 6);
        check("bus released", 16'h0001, {15'h0000, hoe_n});
        core_acc(1'b1, 1'b1, 16'h0000);
    endtask : sc_read16

    task automatic sc_refuse;
        hxfer(1'b1, 1'b0, 1'b1, 16'h5555);
        stays_ready("deselected");
        set_mode(1'b1, 1'b1);
        hxfer(1'b1, 1'b0, 1'b0, 16'h6666);
        stays_ready("serial mode");
        check("word kept", 16'h0F0F, cword);
    endtask : sc_refuse

    task automatic sc_byte8;
        set_mode(1'b0, 1'b1);
        hxfer(1'b1, 1'b1, 1'b0, 16'hFF5A);
        wait_ready(1'b0, 6);
        @(negedge clock_i);
        check("instr byte", 16'h005A, cword);
        core_acc(1'b1, 1'b1, 16'h0000);
        hxfer(1'b1, 1'b0, 1'b0, 16'hAB12);
        stays_ready("first byte");
        hxfer(1'b1, 1'b0, 1'b0, 16'hCD34);
        wait_ready(1'b0, 6);
        @(negedge clock_i);
        check("byte pair", 16'h1234, cword);
        core_acc(1'b1, 1'b1, 16'h0000);
    endtask : sc_byte8

    task automatic sc_byte16;
        set_mode(1'b1, 1'b0);
        hxfer(1'b1, 1'b1, 1'b0, 16'h00C1);
        stays_ready("instr high");
        hxfer(1'b1, 1'b1, 1'b0, 16'h00D2);
        wait_ready(1'b0, 6);
        @(negedge clock_i);
        check("instr pair", 16'hC1D2, cword);
        wait_ready(1'b1, BUSY_CYC + 4);
        check("busy hold", 16'h0001, {15'h0000, n >= BUSY_CYC - 6});
    endtask : sc_byte16

    initial begin
        repeat (10) @(posedge clock_i);
        sys_rst_i <= 1'b0;
        sc_reset();
        sc_word16();
        sc_read16();
        sc_refuse();
        sc_byte8();
        sc_byte16();
        final_report();
    end
endmodule : tb
